// file: dv/aesp_host_model.sv
// Host side bus master model that reads and clears status flags
`timescale 1ns/1ps
`default_nettype none

module aesp_host_model (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output aesp_pkg::aesp_addr_t paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    import aesp_pkg::*;

    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        pstrb = 4'hf;
    end

    // ----------------------------------------
    // One transfer; request held until pready is seen high, for at most 16 cycles
    // ----------------------------------------
    task automatic xfer(input logic [3:0] st, input logic wr, input aesp_addr_t a, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err, output logic ok);
        ok = 1'b0;
        rd = '0;
        err = 1'b0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        pstrb <= st;
        @(posedge pclk);
        penable <= 1'b1;
        // Bounded so a dead slave cannot hang the run
        for (int i = 0; i < 16 && !ok; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) begin
                ok = 1'b1;
                rd = prdata;
                err = pslverr;
            end
        end
        psel <= 1'b0;
        penable <= 1'b0;
        // Released lines show a changing pattern, not the last value
        pwdata <= ~wd;
        paddr <= ~a;
    endtask : xfer

    // Read flags, then write the same value back to clear what was handled
    task automatic service(output logic [31:0] v, output logic ok);
        logic e;
        logic [31:0] wr_rd;
        xfer(4'hf, 1'b0, {`AESP_IDX_STATUS, 2'h0}, '0, v, e, ok);
        if (ok) begin
            xfer(4'hf, 1'b1, {`AESP_IDX_STATUS, 2'h0}, v, wr_rd, e, ok);
        end
    endtask : service
endmodule : aesp_host_model

`default_nettype wire

// file: dv/als_event_status_persistence_tb.sv
// Self-checking bench of the light event status block
`timescale 1ns/1ps
`default_nettype none
`include "aesp_cfg.svh"

module als_event_status_persistence_tb;
    import aesp_pkg::*;

    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, irq_out;
    aesp_addr_t paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    aesp_cnt_t persist_count;
    // Events: fd, offs, base, zero, done, sat, sample
    logic [6:0] ev = '0;
    logic oor = 1'b0;
    logic [3:0] sdet = 4'h5;
    int n_fail = 0;
    int compares = 0;

    always #20 pclk = ~pclk;

    aesp_host_model aesp_host_model_i (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    aesp_event_status aesp_event_status_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sample_valid(ev[0]), .out_of_range(oor), .sat_event(ev[1]),
        .sat_detail(sdet), .cal_done(ev[2]), .cal_zero_evt(ev[3]), .cal_base_evt(ev[4]),
        .cal_offs_evt(ev[5]), .fd_change(ev[6]), .irq_out(irq_out), .persist_count(persist_count));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic conclude();
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : conclude

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic bus(input logic [3:0] st, input logic w, input logic [9:0] idx, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        logic ok;
        aesp_host_model_i.xfer(st, w, {idx, 2'h0}, d, r, e, ok);
        if (!ok) begin
            n_fail++;
            conclude();
        end
    endtask : bus

    task automatic wr(input logic [9:0] idx, input aesp_byte_t d);
        logic [31:0] r;
        logic e;
        bus(4'hf, 1'b1, idx, {24'h0, d}, r, e);
    endtask : wr

    task automatic rdchk(input logic [9:0] idx, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        bus(4'hf, 1'b0, idx, '0, r, e);
        check(r, exp);
    endtask : rdchk

    task automatic pulse(input logic [6:0] m);
        @(posedge pclk);
        ev <= m;
        @(posedge pclk);
        ev <= '0;
        @(posedge pclk);
    endtask : pulse

    task automatic samples(input int n, input logic o);
        repeat (n) begin
            oor <= o;
            pulse(7'h01);
        end
    endtask : samples

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        rdchk(`AESP_IDX_STATUS, 32'h00);
        rdchk(`AESP_IDX_PERSISTENCE_CONFIG, 32'h00);
        check({31'h0, irq_out}, 32'h0);
    endtask : t_reset

    task automatic t_persist();
        int need;
        wr(`AESP_IDX_ENABLE, 8'h08);
        for (int c = 0; c < 16; c++) begin
            need = (c < 4) ? c : 5 * (c - 3);
            wr(`AESP_IDX_PERSISTENCE_CONFIG, 8'(c));
            samples(1, 1'b0);
            wr(`AESP_IDX_STATUS, 8'h08);
            if (c == 0) begin
                samples(1, 1'b0);
                rdchk(`AESP_IDX_STATUS, 32'h08);
            end else begin
                samples(need - 1, 1'b1);
                samples(1, 1'b0);
                check({26'h0, persist_count}, 32'h0);
                samples(need - 1, 1'b1);
                rdchk(`AESP_IDX_STATUS, 32'h00);
                samples(1, 1'b1);
                rdchk(`AESP_IDX_STATUS, 32'h08);
            end
            wr(`AESP_IDX_STATUS, 8'h08);
        end
    endtask : t_persist

    task automatic t_w1c();
        logic [31:0] v;
        logic ok;
        wr(`AESP_IDX_PERSISTENCE_CONFIG, 8'h00);
        wr(`AESP_IDX_ENABLE, 8'h8b);
        pulse(7'h46);
        rdchk(`AESP_IDX_STATUS, 32'h83);
        check({31'h0, irq_out}, 32'h1);
        rdchk(`AESP_IDX_SATDET, 32'h09);
        sdet <= 4'ha;
        rdchk(`AESP_IDX_SATDET, 32'h12);
        rdchk(`AESP_IDX_SYSDET, 32'h08);
        wr(`AESP_IDX_STATUS, 8'h00);
        rdchk(`AESP_IDX_STATUS, 32'h83);
        wr(`AESP_IDX_STATUS, 8'h80);
        rdchk(`AESP_IDX_STATUS, 32'h03);
        aesp_host_model_i.service(v, ok);
        check(v, 32'h03);
        rdchk(`AESP_IDX_STATUS, 32'h00);
        rdchk(`AESP_IDX_SYSDET, 32'h00);
        repeat (3) @(posedge pclk);
        check({31'h0, irq_out}, 32'h0);
        // Flicker change lands on the very edge of the clearing write
        fork
            wr(`AESP_IDX_STATUS, 8'h01);
            begin
                repeat (2) @(posedge pclk);
                ev <= 7'h40;
                @(posedge pclk);
                ev <= '0;
            end
        join
        rdchk(`AESP_IDX_STATUS, 32'h01);
        rdchk(`AESP_IDX_SYSDET, 32'h08);
        wr(`AESP_IDX_STATUS, 8'h01);
    endtask : t_w1c

    task automatic t_gate();
        logic [31:0] r;
        logic e;
        wr(`AESP_IDX_ENABLE, 8'h00);
        pulse(7'h46);
        samples(1, 1'b1);
        rdchk(`AESP_IDX_STATUS, 32'h00);
        check({31'h0, irq_out}, 32'h0);
        wr(`AESP_IDX_ENABLE, 8'h80);
        pulse(7'h46);
        samples(1, 1'b1);
        rdchk(`AESP_IDX_STATUS, 32'h80);
        // Lane 0 strobe low: the write must not land
        bus(4'he, 1'b1, `AESP_IDX_ENABLE, 32'h0000_008b, r, e);
        rdchk(`AESP_IDX_ENABLE, 32'h80);
        wr(`AESP_IDX_STATUS, 8'hff);
        rdchk(`AESP_IDX_STATUS, 32'h00);
    endtask : t_gate

    task automatic t_cal();
        logic [31:0] r;
        logic e;
        for (int i = 0; i < 3; i++) begin
            wr(`AESP_IDX_ENABLE, 8'h02 | (8'h10 << i));
            pulse(7'h38);
            rdchk(`AESP_IDX_STATUS, 32'h02);
            rdchk(`AESP_IDX_CALCAUSE, 32'h1 << i);
            wr(`AESP_IDX_STATUS, 8'h02);
            rdchk(`AESP_IDX_CALCAUSE, 32'h0);
        end
        // Unmapped place answers with an error and reads zero
        bus(4'hf, 1'b0, 10'h000, '0, r, e);
        check({r[31:1], e}, 32'h1);
    endtask : t_cal

    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_persist();
        t_w1c();
        t_gate();
        t_cal();
        conclude();
    end

    initial begin
        repeat (100000) @(posedge pclk);
        n_fail++;
        conclude();
    end
endmodule : als_event_status_persistence_tb

`default_nettype wire

// file: verilog/aesp_cfg.svh
// Register indices, field positions, reset values and timing counts
`ifndef AESP_CFG_SVH
`define AESP_CFG_SVH

// ----------------------------------------
// Register indices (byte address = 4 x index)
// ----------------------------------------
`define AESP_IDX_STATUS 10'h093
`define AESP_IDX_SATDET 10'h0a3
`define AESP_IDX_SYSDET 10'h0a6
`define AESP_IDX_PERSISTENCE_CONFIG 10'h0bd
`define AESP_IDX_ENABLE 10'h0c0
`define AESP_IDX_CALCAUSE 10'h0c1

// ----------------------------------------
// Field positions
// ----------------------------------------
`define AESP_BIT_SAT 7
`define AESP_BIT_LIGHT 3
`define AESP_BIT_CAL 1
`define AESP_BIT_SYS 0
`define AESP_BIT_SYSDET_FD 3
`define AESP_BIT_EN_ZERO 4
`define AESP_BIT_EN_BASE 5
`define AESP_BIT_EN_OFFS 6
`define AESP_STATUS_MASK 8'h8b
`define AESP_PERSISTENCE_CONFIG_MASK 8'h0f

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define AESP_RST_STATUS 8'h00
`define AESP_RST_PERSISTENCE_CONFIG 8'h00
`define AESP_RST_ENABLE 8'h00
`define AESP_PERSISTENCE_CONFIG_STEP 6'h05
`define AESP_PERSISTENCE_CONFIG_BASE 4'h3
`define AESP_CNT_MAX 6'h3f

`endif

// file: verilog/aesp_event_status.sv
// Light event status block: persistence filter, flags and APB registers
// ----------------------------------------
// Operation
// - Code sets consecutive out-of-range count needed
// - Code 0 every cycle, code 1 one sample
// - In-range sample clears the count
// - Writing one clears that status flag
// - Writing zero leaves a flag unchanged
// - Bit 7 saturation, gated by its enable
// - Bit 3 light threshold event, gated
// - Bit 1 calibration event, gated
// - Zero burst, baseline, offset also set bit 1
// - Bit 0 flicker status change, gated
// - Bits 6:4 and 2 read zero
// ----------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "aesp_cfg.svh"

module aesp_event_status (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire aesp_pkg::aesp_addr_t paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sample_valid,
    input wire logic out_of_range,
    input wire logic sat_event,
    input wire logic [3:0] sat_detail,
    input wire logic cal_done,
    input wire logic cal_zero_evt,
    input wire logic cal_base_evt,
    input wire logic cal_offs_evt,
    input wire logic fd_change,
    output logic irq_out,
    output aesp_pkg::aesp_cnt_t persist_count
);
    import aesp_pkg::*;

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    aesp_sel_t sel;
    logic setup_ph;
    logic wr_acc;
    logic wr_lane0;

    assign sel = aesp_decode(paddr);
    assign setup_ph = psel && !penable;
    // Zero-wait slave: every access phase completes
    assign pready = 1'b1;
    assign wr_acc = psel && penable && pwrite;
    assign wr_lane0 = wr_acc && pstrb[0];

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    aesp_byte_t persistence_config_r;
    aesp_byte_t enable_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            persistence_config_r <= `AESP_RST_PERSISTENCE_CONFIG;
        end else if (wr_lane0 && sel == SEL_PERSISTENCE_CONFIG) begin
            persistence_config_r <= pwdata[7:0] & `AESP_PERSISTENCE_CONFIG_MASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_r <= `AESP_RST_ENABLE;
        end else if (wr_lane0 && sel == SEL_ENABLE) begin
            enable_r <= pwdata[7:0] & 8'hfb;
        end
    end

    logic en_sat;
    logic en_light;
    logic en_cal;
    logic en_sys;
    assign en_sat = enable_r[`AESP_BIT_SAT];
    assign en_light = enable_r[`AESP_BIT_LIGHT];
    assign en_cal = enable_r[`AESP_BIT_CAL];
    assign en_sys = enable_r[`AESP_BIT_SYS];

    // ----------------------------------------
    // Persistence filter
    // ----------------------------------------
    logic light_fire;

    aesp_persist_filter u_filter (
        .pclk(pclk),
        .presetn(presetn),
        .code(persistence_config_r[3:0]),
        .sample_valid(sample_valid),
        .out_of_range(out_of_range),
        .fire(light_fire),
        .count(persist_count)
    );

    // ----------------------------------------
    // Event qualification
    // ----------------------------------------
    logic cal_zero_q;
    logic cal_base_q;
    logic cal_offs_q;
    logic cal_any;
    aesp_byte_t status_set;
    aesp_byte_t status_clr;
    aesp_byte_t status;

    // Each side cause only counts while its function is on
    assign cal_zero_q = cal_zero_evt && enable_r[`AESP_BIT_EN_ZERO];
    assign cal_base_q = cal_base_evt && enable_r[`AESP_BIT_EN_BASE];
    assign cal_offs_q = cal_offs_evt && enable_r[`AESP_BIT_EN_OFFS];
    assign cal_any = cal_done || cal_zero_q || cal_base_q || cal_offs_q;

    always_comb begin
        status_set = '0;
        status_set[`AESP_BIT_SAT] = sat_event && en_sat;
        status_set[`AESP_BIT_LIGHT] = light_fire && en_light;
        status_set[`AESP_BIT_CAL] = cal_any && en_cal;
        status_set[`AESP_BIT_SYS] = fd_change && en_sys;
    end

    // Only ones clear, so writing back a read value keeps newer events
    assign status_clr = (wr_lane0 && sel == SEL_STATUS) ?
                        (pwdata[7:0] & `AESP_STATUS_MASK) : 8'h00;

    aesp_w1c_flags #(
        .WIDTH(8)
    ) u_status (
        .pclk(pclk),
        .presetn(presetn),
        .set_in(status_set),
        .clr_in(status_clr),
        .flags(status)
    );

    // ----------------------------------------
    // Detail registers
    // ----------------------------------------
    logic [2:0] cause_r;
    logic sysdet_r;
    logic cal_clr;
    logic sys_clr;

    // Details follow their primary flag: cleared with it, set wins
    assign cal_clr = status_clr[`AESP_BIT_CAL];
    assign sys_clr = status_clr[`AESP_BIT_SYS];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cause_r <= 3'h0;
        end else begin
            cause_r <= (cal_clr ? 3'h0 : cause_r) | {cal_offs_q, cal_base_q, cal_zero_q};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sysdet_r <= 1'b0;
        end else begin
            sysdet_r <= (sysdet_r && !sys_clr) || (fd_change && en_sys);
        end
    end

    aesp_byte_t satdet;
    always_comb begin
        satdet = 8'h00;
        satdet[4] = sat_detail[3];
        satdet[3] = sat_detail[2];
        satdet[1] = sat_detail[1];
        satdet[0] = sat_detail[0];
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    aesp_byte_t rd_mux;

    always_comb begin
        case (sel)
            SEL_STATUS: rd_mux = status & `AESP_STATUS_MASK;
            SEL_SATDET: rd_mux = satdet;
            SEL_SYSDET: rd_mux = {4'h0, sysdet_r, 3'h0};
            SEL_PERSISTENCE_CONFIG: rd_mux = persistence_config_r;
            SEL_ENABLE: rd_mux = enable_r;
            SEL_CALCAUSE: rd_mux = {5'h00, cause_r};
            default: rd_mux = 8'h00;
        endcase
    end

    // Data is captured in the setup cycle so prdata is a flop output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup_ph) begin
            prdata <= (!pwrite) ? {24'h00_0000, rd_mux} : 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else if (setup_ph) begin
            pslverr <= (sel == SEL_NONE);
        end
    end

    // ----------------------------------------
    // Interrupt line
    // ----------------------------------------
    logic irq_r;

    // Registered so the pin never glitches on enable changes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(status & enable_r & `AESP_STATUS_MASK);
        end
    end

    assign irq_out = irq_r;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_status_write(int b);
        wr_lane0 && sel == SEL_STATUS && pwdata[b];
    endsequence

    sequence s_status_keep(int b);
        wr_lane0 && sel == SEL_STATUS && !pwdata[b] && status[b];
    endsequence

    chk_w1c_clears: assert property (
        s_status_write(`AESP_BIT_LIGHT) ##0 !status_set[`AESP_BIT_LIGHT]
        |=> !status[`AESP_BIT_LIGHT])
        else $error("write one did not clear light flag");
    chk_zero_keeps: assert property (
        s_status_keep(`AESP_BIT_SAT) |=> status[`AESP_BIT_SAT] [*2])
        else $error("write zero cleared saturation flag");
    chk_set_wins: assert property (
        s_status_write(`AESP_BIT_SYS) ##0 fd_change && en_sys |=> status[`AESP_BIT_SYS])
        else $error("event lost during clear");
    chk_sat_flag: assert property (
        sat_event && en_sat |=> status[`AESP_BIT_SAT])
        else $error("saturation not flagged");
    chk_light_flag: assert property (
        sample_valid && en_light && persistence_config_r[3:0] == 4'h0 |=> status[`AESP_BIT_LIGHT])
        else $error("light event not flagged");
    chk_cal_flag: assert property (
        cal_done && en_cal |=> status[`AESP_BIT_CAL])
        else $error("calibration done not flagged");
    chk_cal_cause: assert property (
        cal_offs_evt && enable_r[`AESP_BIT_EN_OFFS] && en_cal
        |=> status[`AESP_BIT_CAL] && cause_r[2])
        else $error("offset cause not recorded");
    chk_sys_flag: assert property (
        fd_change && en_sys |=> status[`AESP_BIT_SYS] && sysdet_r)
        else $error("flicker change not flagged");
    chk_reserved_zero: assert property (
        status[6:4] == 3'h0 && !status[2])
        else $error("reserved status bit set");
    chk_disabled_quiet: assert property (
        !en_sat && !status[`AESP_BIT_SAT] |=> !status[`AESP_BIT_SAT])
        else $error("disabled saturation event set flag");
    chk_irq_follows: assert property (
        |(status & enable_r) |=> irq_out)
        else $error("irq low with enabled flag");
    chk_irq_quiet: assert property (
        !(|(status & enable_r)) |=> !irq_out)
        else $error("irq high with no enabled flag");
    // Detail registers clear with their flag; a new cause still wins
    chk_cause_clear: assert property (
        cal_clr && !cal_zero_q && !cal_base_q && !cal_offs_q |=> cause_r == 3'h0)
        else $error("calibration cause kept after clear");
    chk_cause_gated: assert property (
        cal_zero_evt && !enable_r[`AESP_BIT_EN_ZERO] && !cause_r[0]
        |=> !cause_r[0])
        else $error("disabled zero burst recorded");
    chk_sysdet_clear: assert property (
        sys_clr && !(fd_change && en_sys) |=> !sysdet_r)
        else $error("system detail kept after clear");

    // ----------------------------------------
    // Bus checks
    // ----------------------------------------
    // Read data is taken in setup, so the access phase shows last cycle's status
    sequence s_status_read;
        setup_ph && !pwrite && sel == SEL_STATUS;
    endsequence

    sequence s_access;
        psel && penable;
    endsequence

    chk_pready_high: assert property (
        s_access |-> pready)
        else $error("pready low in access phase");
    chk_rdata_upper: assert property (
        prdata[31:8] == 24'h00_0000)
        else $error("read data upper bits set");
    chk_status_read: assert property (
        s_status_read ##1 s_access
        |-> prdata == {24'h00_0000, $past(status) & `AESP_STATUS_MASK})
        else $error("status read data wrong");
    chk_slverr_map: assert property (
        setup_ph && sel == SEL_NONE |=> pslverr)
        else $error("unmapped access without error");
    chk_slverr_clear: assert property (
        setup_ph && sel != SEL_NONE |=> !pslverr)
        else $error("mapped access flagged error");
    chk_strb_ignored: assert property (
        s_access ##0 pwrite && !pstrb[0]
        |=> enable_r == $past(enable_r) && persistence_config_r == $past(persistence_config_r))
        else $error("write without lane strobe landed");
    chk_persistence_config_write: assert property (
        wr_lane0 && sel == SEL_PERSISTENCE_CONFIG
        |=> persistence_config_r == ($past(pwdata[7:0]) & `AESP_PERSISTENCE_CONFIG_MASK))
        else $error("persistence write lost");
    chk_persistence_config_reserved: assert property (
        persistence_config_r[7:4] == 4'h0)
        else $error("persistence upper bits set");
    chk_enable_write: assert property (
        wr_lane0 && sel == SEL_ENABLE
        |=> enable_r == ($past(pwdata[7:0]) & 8'hfb))
        else $error("enable write lost");

endmodule : aesp_event_status

`default_nettype wire

// file: verilog/aesp_persist_filter.sv
// Consecutive out-of-range sample filter for the light event
`timescale 1ns/1ps
`default_nettype none
`include "aesp_cfg.svh"

module aesp_persist_filter (
    input wire logic pclk,
    input wire logic presetn,
    input wire aesp_pkg::aesp_pcode_t code,
    input wire logic sample_valid,
    input wire logic out_of_range,
    output logic fire,
    output aesp_pkg::aesp_cnt_t count
);
    import aesp_pkg::*;

    aesp_cnt_t cnt_r;
    aesp_cnt_t cnt_nxt;
    aesp_cnt_t need;

    assign need = aesp_need(code);
    assign count = cnt_r;

    // Saturate so a long run never wraps back below the target
    always_comb begin
        cnt_nxt = cnt_r;
        if (sample_valid) begin
            if (!out_of_range) begin
                cnt_nxt = '0;
            end else if (cnt_r != `AESP_CNT_MAX) begin
                cnt_nxt = cnt_r + 6'h01;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // Code 0 fires on every completed cycle, in range or not
    assign fire = sample_valid && ((code == 4'h0) ||
                  (out_of_range && cnt_nxt >= need));

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_count_inrange_zero: assert property (
        sample_valid && !out_of_range |=> cnt_r == 6'h00)
        else $error("count not cleared by in-range sample");
    chk_fire_on_target: assert property (
        sample_valid && out_of_range && code >= 4'h1 && cnt_r == need - 6'h01 |-> fire)
        else $error("no fire at persistence target");
    chk_no_early_fire: assert property (
        code != 4'h0 && sample_valid && {1'b0, cnt_r} + 7'h01 < {1'b0, need} |-> !fire)
        else $error("fire before persistence target");
    chk_code_zero_fire: assert property (
        code == 4'h0 && sample_valid |-> fire)
        else $error("code 0 cycle did not fire");

endmodule : aesp_persist_filter

`default_nettype wire

// file: verilog/aesp_pkg.sv
// Types and shared arithmetic of the light event status block
`default_nettype none
`include "aesp_cfg.svh"

package aesp_pkg;

    typedef logic [7:0] aesp_byte_t;
    typedef logic [3:0] aesp_pcode_t;
    typedef logic [5:0] aesp_cnt_t;
    typedef logic [11:0] aesp_addr_t;

    typedef enum logic [5:0] {
        SEL_NONE = 6'h00,
        SEL_STATUS = 6'h01,
        SEL_SATDET = 6'h02,
        SEL_SYSDET = 6'h04,
        SEL_PERSISTENCE_CONFIG = 6'h08,
        SEL_ENABLE = 6'h10,
        SEL_CALCAUSE = 6'h20
    } aesp_sel_t;

    // Samples needed before a light event; code 0 means every cycle
    function automatic aesp_cnt_t aesp_need(input aesp_pcode_t code);
        aesp_cnt_t d;
        d = {2'h0, code - `AESP_PERSISTENCE_CONFIG_BASE};
        if (code <= `AESP_PERSISTENCE_CONFIG_BASE) begin
            return {2'h0, code};
        end
        return 6'((`AESP_PERSISTENCE_CONFIG_STEP * d));
    endfunction : aesp_need

    function automatic aesp_sel_t aesp_decode(input aesp_addr_t a);
        if (a[1:0] != 2'h0) return SEL_NONE;
        case (a[11:2])
            `AESP_IDX_STATUS: return SEL_STATUS;
            `AESP_IDX_SATDET: return SEL_SATDET;
            `AESP_IDX_SYSDET: return SEL_SYSDET;
            `AESP_IDX_PERSISTENCE_CONFIG: return SEL_PERSISTENCE_CONFIG;
            `AESP_IDX_ENABLE: return SEL_ENABLE;
            `AESP_IDX_CALCAUSE: return SEL_CALCAUSE;
            default: return SEL_NONE;
        endcase
    endfunction : aesp_decode

endpackage : aesp_pkg

`default_nettype wire

// file: verilog/aesp_w1c_flags.sv
// Sticky flags: hardware set wins, software writes one to clear
`timescale 1ns/1ps
`default_nettype none

module aesp_w1c_flags #(
    parameter int WIDTH = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] set_in,
    input wire logic [WIDTH-1:0] clr_in,
    output logic [WIDTH-1:0] flags
);
    logic [WIDTH-1:0] flags_r;

    // Set over clear: an event in the clear cycle survives
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_r <= '0;
        end else begin
            flags_r <= (flags_r & ~clr_in) | set_in;
        end
    end

    assign flags = flags_r;

endmodule : aesp_w1c_flags

`default_nettype wire
